// ==== core/rtcisp_pkg.sv ====
/*
  Shared constants and types for the two-wire register port: slave address,
  pointer reset value, bus timing and the state and command encodings.
  Assumes both ends import it whole.
*/
package rtcisp_pkg;
  // Reference clock and bus half period, in ns
  localparam int RTCISP_REF_CLK_NS = 10;
  localparam int RTCISP_SCL_HALF_NS = 1250;
  localparam int RTCISP_SCL_HALF_CYC = RTCISP_SCL_HALF_NS / RTCISP_REF_CLK_NS;
  localparam logic [7:0] RTCISP_HALF_LAST = 8'(RTCISP_SCL_HALF_CYC - 1);

  // Fixed 7-bit slave address and read direction code
  localparam logic [6:0] RTCISP_SLAVE_ADDR = 7'h32;
  localparam logic RTCISP_DIR_READ = 1'b1;

  // Register pointer after reset, bits per byte
  localparam logic [7:0] RTCISP_PTR_RST = 8'h00;
  localparam logic [3:0] RTCISP_BYTE_BITS = 4'h8;
  localparam logic [3:0] RTCISP_LAST_BIT = 4'h7;

  typedef enum logic [2:0] {
    RTCISP_S_IDLE = 3'b000,
    RTCISP_S_RX = 3'b001,
    RTCISP_S_ACK = 3'b010,
    RTCISP_S_TX = 3'b011,
    RTCISP_S_MACK = 3'b100
  } rtcisp_dev_state_t;

  typedef enum logic [1:0] {
    RTCISP_PH_ADDR = 2'b00,
    RTCISP_PH_REG = 2'b01,
    RTCISP_PH_DATA = 2'b10
  } rtcisp_phase_t;

  typedef enum logic [1:0] {
    RTCISP_CMD_START = 2'b00,
    RTCISP_CMD_WRITE = 2'b01,
    RTCISP_CMD_READ = 2'b10,
    RTCISP_CMD_STOP = 2'b11
  } rtcisp_cmd_t;

  typedef enum logic [2:0] {
    RTCISP_H_IDLE = 3'b000,
    RTCISP_H_START = 3'b001,
    RTCISP_H_BIT = 3'b010,
    RTCISP_H_ACK = 3'b011,
    RTCISP_H_HOLD = 3'b100,
    RTCISP_H_STOP = 3'b101
  } rtcisp_host_state_t;
endpackage

// ==== core/rtcisp_if.sv ====
/*
  Two-wire bus between controller and register port, open-drain wires
  resolved from the drive enables. Undriven lines read high through its own pull-up.
*/
`timescale 1ns/1ps
interface rtcisp_if;
  logic m_scl_o;
  logic m_scl_oe;
  logic m_sda_o;
  logic m_sda_oe;
  logic s_sda_o;
  logic s_sda_oe;
  logic scl;
  logic sda;

  // Wired-AND with pull-up
  assign scl = m_scl_oe ? m_scl_o : 1'b1;
  assign sda = (m_sda_oe ? m_sda_o : 1'b1) & (s_sda_oe ? s_sda_o : 1'b1);

  modport host (output m_scl_o, output m_scl_oe, output m_sda_o, output m_sda_oe,
                input scl, input sda);
  modport dev (output s_sda_o, output s_sda_oe, input scl, input sda);
endinterface

// ==== core/rtcisp_dev.sv ====
/*
  Register port slave end: decodes start/stop, matches the slave address,
  receives register address and data, sends register data with pointer
  auto-increment. Runs on the link clock; the register file outside answers
  reg_rdata combinationally from reg_addr in the same clock.
*/
// How it works
// - Controller is master, this end slave
// - No limit on bytes between start, stop
// - Transmitter releases data for ninth clock
// - Receiver pulls data low after eighth bit
// - Acknowledge lasts exactly one clock, then release
// - Master stops after the last write acknowledge or a read no-acknowledge
// - Master ends read with no-acknowledge, stop
// - Write: start, address, register, data, stop
// - First byte at given address, then increment
// - Each data byte written at pointer, acknowledged
// - Addressed read uses repeated start, read address
// - Read sends register named in write phase
// - Pointer increments after each sent byte
// - Bare read continues from last plus one
// - Master acknowledges to get next register
// - Seven-bit address plus direction, one byte
// - Start, stop are data edges, clock high
// - Data changes only while clock low
`timescale 1ns/1ps
module rtcisp_dev
  import rtcisp_pkg::*;
(
  input wire logic link_clk, // Link clock
  input wire logic arst_n, // Asynchronous reset, active low
  input wire logic clk_en, // Freezes all state while low
  rtcisp_if.dev bus, // Two-wire bus
  output logic [7:0] reg_addr, // Register pointer
  output logic [7:0] reg_wdata, // Write data
  output logic reg_wr, // Write strobe, one cycle
  input wire logic [7:0] reg_rdata, // Read data for reg_addr
  output logic busy // Addressed and in a transfer
);
  logic [1:0] scl_sync_reg;
  logic [1:0] sda_sync_reg;
  logic scl_q_reg;
  logic sda_q_reg;
  logic scl_s;
  logic sda_s;
  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;
  rtcisp_dev_state_t st_reg;
  rtcisp_phase_t phase_reg;
  logic [3:0] cnt_reg;
  logic [7:0] shreg_reg;
  logic rw_reg;
  logic mack_reg;
  logic sda_oe_reg;
  logic [7:0] ptr_reg;
  logic wr_reg;
  logic [7:0] wdata_reg;
  logic busy_reg;
  logic rx_done;
  logic addr_hit;
  logic take_byte;
  logic ack_end;
  logic tx_next;
  logic tx_last;
  logic mack_end;
  logic load_tx;

  // Pin synchronisers plus one delayed copy for edge detection
  always_ff @(posedge link_clk or negedge arst_n) begin
    if (!arst_n) begin
      scl_sync_reg <= 2'h3;
      sda_sync_reg <= 2'h3;
      scl_q_reg <= 1'b1;
      sda_q_reg <= 1'b1;
    end else if (clk_en) begin
      scl_sync_reg <= {scl_sync_reg[0], bus.scl};
      sda_sync_reg <= {sda_sync_reg[0], bus.sda};
      scl_q_reg <= scl_sync_reg[1];
      sda_q_reg <= sda_sync_reg[1];
    end
  end

  assign scl_s = scl_sync_reg[1];
  assign sda_s = sda_sync_reg[1];
  assign scl_rise = scl_s & ~scl_q_reg;
  assign scl_fall = ~scl_s & scl_q_reg;
  assign start_det = scl_s & scl_q_reg & sda_q_reg & ~sda_s;
  assign stop_det = scl_s & scl_q_reg & ~sda_q_reg & sda_s;

  // Byte and slot events
  assign rx_done = (st_reg == RTCISP_S_RX) & scl_fall & (cnt_reg == RTCISP_BYTE_BITS);
  assign addr_hit = (shreg_reg[7:1] == RTCISP_SLAVE_ADDR);
  assign take_byte = rx_done & ((phase_reg != RTCISP_PH_ADDR) | addr_hit);
  assign ack_end = (st_reg == RTCISP_S_ACK) & scl_fall;
  assign tx_next = (st_reg == RTCISP_S_TX) & scl_fall;
  assign tx_last = tx_next & (cnt_reg == RTCISP_BYTE_BITS);
  assign mack_end = (st_reg == RTCISP_S_MACK) & scl_fall;
  assign load_tx = (ack_end & (phase_reg == RTCISP_PH_ADDR) & rw_reg) | (mack_end & mack_reg);

  // Transfer sequencer; the master's start and stop override every clock-edge step
  always_ff @(posedge link_clk or negedge arst_n) begin
    if (!arst_n) begin
      st_reg <= RTCISP_S_IDLE;
      phase_reg <= RTCISP_PH_ADDR;
      cnt_reg <= 4'h0;
      shreg_reg <= 8'h00;
      rw_reg <= 1'b0;
      mack_reg <= 1'b0;
    end else if (clk_en) begin
      if (start_det) begin
        // Start or repeated start: next byte is an address
        st_reg <= RTCISP_S_RX;
        phase_reg <= RTCISP_PH_ADDR;
        cnt_reg <= 4'h0;
      end else if (stop_det) begin
        st_reg <= RTCISP_S_IDLE;
      end else begin
        case (st_reg)
          RTCISP_S_RX: begin
            if (scl_rise) begin
              shreg_reg <= {shreg_reg[6:0], sda_s};
              cnt_reg <= cnt_reg + 4'h1;
            end else if (rx_done) begin
              if (!take_byte) begin
                st_reg <= RTCISP_S_IDLE;
              end else begin
                st_reg <= RTCISP_S_ACK;
                if (phase_reg == RTCISP_PH_ADDR) begin
                  rw_reg <= shreg_reg[0] == RTCISP_DIR_READ;
                end
              end
            end
          end
          RTCISP_S_ACK: begin
            if (scl_fall) begin
              if (load_tx) begin
                st_reg <= RTCISP_S_TX;
                shreg_reg <= {reg_rdata[6:0], 1'b0};
                cnt_reg <= 4'h1;
              end else begin
                // Any number of further bytes is taken
                st_reg <= RTCISP_S_RX;
                cnt_reg <= 4'h0;
                phase_reg <= (phase_reg == RTCISP_PH_ADDR) ? RTCISP_PH_REG : RTCISP_PH_DATA;
              end
            end
          end
          RTCISP_S_TX: begin
            if (tx_last) begin
              st_reg <= RTCISP_S_MACK;
              mack_reg <= 1'b0;
            end else if (tx_next) begin
              shreg_reg <= {shreg_reg[6:0], 1'b0};
              cnt_reg <= cnt_reg + 4'h1;
            end
          end
          RTCISP_S_MACK: begin
            if (scl_rise) begin
              mack_reg <= ~sda_s;
            end else if (mack_end) begin
              if (mack_reg) begin
                st_reg <= RTCISP_S_TX;
                shreg_reg <= {reg_rdata[6:0], 1'b0};
                cnt_reg <= 4'h1;
              end else begin
                st_reg <= RTCISP_S_IDLE;
              end
            end
          end
          default: begin
            st_reg <= RTCISP_S_IDLE;
          end
        endcase
      end
    end
  end

  // Data line drive, changed just after a clock fall; start and stop release it
  always_ff @(posedge link_clk or negedge arst_n) begin
    if (!arst_n) begin
      sda_oe_reg <= 1'b0;
    end else if (clk_en) begin
      if (start_det || stop_det) begin
        sda_oe_reg <= 1'b0;
      end else if (take_byte) begin
        sda_oe_reg <= 1'b1;
      end else if (ack_end) begin
        sda_oe_reg <= load_tx ? ~reg_rdata[7] : 1'b0;
      end else if (tx_next) begin
        sda_oe_reg <= tx_last ? 1'b0 : ~shreg_reg[7];
      end else if (mack_end) begin
        sda_oe_reg <= mack_reg ? ~reg_rdata[7] : 1'b0;
      end
    end
  end

  // Register pointer; no stop or start touches it
  always_ff @(posedge link_clk or negedge arst_n) begin
    if (!arst_n) begin
      ptr_reg <= RTCISP_PTR_RST;
    end else if (clk_en) begin
      if (take_byte && phase_reg == RTCISP_PH_REG) begin
        ptr_reg <= shreg_reg;
      end else if (ack_end && phase_reg == RTCISP_PH_DATA) begin
        ptr_reg <= ptr_reg + 8'h01;
      end else if (tx_last) begin
        // Next bare read starts one past the last sent
        ptr_reg <= ptr_reg + 8'h01;
      end
    end
  end

  // Write strobe at the pointer
  always_ff @(posedge link_clk or negedge arst_n) begin
    if (!arst_n) begin
      wr_reg <= 1'b0;
      wdata_reg <= 8'h00;
    end else if (clk_en) begin
      wr_reg <= take_byte && phase_reg == RTCISP_PH_DATA;
      if (take_byte && phase_reg == RTCISP_PH_DATA) begin
        wdata_reg <= shreg_reg;
      end
    end
  end

  always_ff @(posedge link_clk or negedge arst_n) begin
    if (!arst_n) begin
      busy_reg <= 1'b0;
    end else if (clk_en) begin
      busy_reg <= (st_reg != RTCISP_S_IDLE) && !(st_reg == RTCISP_S_RX &&
                  phase_reg == RTCISP_PH_ADDR);
    end
  end

  assign bus.s_sda_o = 1'b0;
  assign bus.s_sda_oe = sda_oe_reg;
  assign reg_addr = ptr_reg;
  assign reg_wdata = wdata_reg;
  assign reg_wr = wr_reg;
  assign busy = busy_reg;
endmodule

// ==== core/rtcisp_host.sv ====
/*
  Controller end: byte-level bus master. Makes the bus clock from ref_clk
  by a divider, issues start, repeated start, write, read and stop on
  command. Assumes the slave does not stretch the clock.
*/
`timescale 1ns/1ps
module rtcisp_host
  import rtcisp_pkg::*;
(
  input wire logic ref_clk, // Reference clock, 100 MHz
  input wire logic arst_n, // Asynchronous reset, active low
  input wire logic clk_en, // Freezes all state while low
  rtcisp_if.host bus, // Two-wire bus
  input wire logic cmd_valid, // Command request
  input wire logic [1:0] cmd_code, // rtcisp_cmd_t code
  input wire logic [7:0] cmd_byte, // Byte to send after start or write
  input wire logic cmd_last, // Read: last byte, answer no-ack
  output logic cmd_ready, // Command can be taken
  output logic rsp_valid, // Byte slot done, one cycle
  output logic [7:0] rsp_byte, // Byte read
  output logic rsp_ack // Acknowledge seen in the slot
);
  rtcisp_host_state_t st_reg;
  logic [1:0] ph_reg;
  logic [7:0] tick_reg;
  logic [3:0] bitn_reg;
  logic [7:0] shreg_reg;
  logic rd_reg;
  logic last_reg;
  logic scl_oe_reg;
  logic sda_oe_reg;
  logic [1:0] sda_sync_reg;
  logic ready_reg;
  logic rsp_valid_reg;
  logic [7:0] rsp_byte_reg;
  logic rsp_ack_reg;
  logic accept;
  logic tick;

  assign accept = cmd_valid & ready_reg;
  assign tick = (tick_reg == RTCISP_HALF_LAST);

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      sda_sync_reg <= 2'h3;
    end else if (clk_en) begin
      sda_sync_reg <= {sda_sync_reg[0], bus.sda};
    end
  end

  // Half period divider for the bus clock
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      tick_reg <= 8'h00;
    end else if (clk_en) begin
      tick_reg <= (accept || tick) ? 8'h00 : tick_reg + 8'h01;
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      st_reg <= RTCISP_H_IDLE;
      ph_reg <= 2'h0;
      bitn_reg <= 4'h0;
      shreg_reg <= 8'h00;
      rd_reg <= 1'b0;
      last_reg <= 1'b0;
      scl_oe_reg <= 1'b0;
      sda_oe_reg <= 1'b0;
      ready_reg <= 1'b1;
      rsp_valid_reg <= 1'b0;
      rsp_byte_reg <= 8'h00;
      rsp_ack_reg <= 1'b0;
    end else if (clk_en) begin
      rsp_valid_reg <= 1'b0;
      case (st_reg)
        RTCISP_H_IDLE, RTCISP_H_HOLD: begin
          if (accept) begin
            ph_reg <= 2'h0;
            bitn_reg <= 4'h0;
            shreg_reg <= cmd_byte;
            rd_reg <= cmd_code == RTCISP_CMD_READ;
            last_reg <= cmd_last;
            if (cmd_code == RTCISP_CMD_START) begin
              ready_reg <= 1'b0;
              st_reg <= RTCISP_H_START;
            end else if (st_reg == RTCISP_H_HOLD) begin
              ready_reg <= 1'b0;
              // Stop only once the last slot has closed
              st_reg <= (cmd_code == RTCISP_CMD_STOP) ? RTCISP_H_STOP : RTCISP_H_BIT;
            end
          end
        end
        RTCISP_H_START: begin
          if (tick) begin
            ph_reg <= ph_reg + 2'h1;
            case (ph_reg)
              2'h0: sda_oe_reg <= 1'b0;
              2'h1: scl_oe_reg <= 1'b0;
              2'h2: sda_oe_reg <= 1'b1;
              default: begin
                scl_oe_reg <= 1'b1;
                st_reg <= RTCISP_H_BIT;
              end
            endcase
          end
        end
        RTCISP_H_BIT: begin
          if (tick) begin
            if (ph_reg == 2'h0) begin
              sda_oe_reg <= rd_reg ? 1'b0 : ~shreg_reg[7];
              ph_reg <= 2'h1;
            end else if (ph_reg == 2'h1) begin
              scl_oe_reg <= 1'b0;
              ph_reg <= 2'h2;
            end else begin
              shreg_reg <= {shreg_reg[6:0], sda_sync_reg[1]};
              scl_oe_reg <= 1'b1;
              bitn_reg <= bitn_reg + 4'h1;
              ph_reg <= 2'h0;
              if (bitn_reg == RTCISP_LAST_BIT) begin
                st_reg <= RTCISP_H_ACK;
              end
            end
          end
        end
        RTCISP_H_ACK: begin
          if (tick) begin
            if (ph_reg == 2'h0) begin
              // Ack to continue, no-ack on the last read byte
              sda_oe_reg <= rd_reg ? ~last_reg : 1'b0;
              ph_reg <= 2'h1;
            end else if (ph_reg == 2'h1) begin
              scl_oe_reg <= 1'b0;
              ph_reg <= 2'h2;
            end else begin
              scl_oe_reg <= 1'b1;
              ph_reg <= 2'h0;
              rsp_valid_reg <= 1'b1;
              rsp_byte_reg <= shreg_reg;
              rsp_ack_reg <= ~sda_sync_reg[1];
              if (rd_reg && last_reg) begin
                st_reg <= RTCISP_H_STOP;
              end else begin
                st_reg <= RTCISP_H_HOLD;
                ready_reg <= 1'b1;
              end
            end
          end
        end
        RTCISP_H_STOP: begin
          if (tick) begin
            ph_reg <= ph_reg + 2'h1;
            if (ph_reg == 2'h0) begin
              sda_oe_reg <= 1'b1;
            end else if (ph_reg == 2'h1) begin
              scl_oe_reg <= 1'b0;
            end else begin
              sda_oe_reg <= 1'b0;
              st_reg <= RTCISP_H_IDLE;
              ready_reg <= 1'b1;
            end
          end
        end
        default: begin
          st_reg <= RTCISP_H_IDLE;
        end
      endcase
    end
  end

  assign bus.m_scl_o = 1'b0;
  assign bus.m_sda_o = 1'b0;
  assign bus.m_scl_oe = scl_oe_reg;
  assign bus.m_sda_oe = sda_oe_reg;
  assign cmd_ready = ready_reg;
  assign rsp_valid = rsp_valid_reg;
  assign rsp_byte = rsp_byte_reg;
  assign rsp_ack = rsp_ack_reg;
endmodule

// ==== sim/rtcisp_sva.sv ====
/*
  Wire checks for the two-wire register port, sampled on ref_clk.
  Assumes the bench ties it to the interface joining both ends.
*/
`timescale 1ns/1ps
module rtcisp_sva
  import rtcisp_pkg::*;
(
  input wire logic ref_clk, // Reference clock
  input wire logic arst_n, // Asynchronous reset, active low
  input wire logic scl, // Resolved clock line
  input wire logic sda, // Resolved data line
  input wire logic m_sda_oe, // Controller data drive
  input wire logic s_sda_oe // Port data drive
);
  logic scl_q_reg, sda_q_reg, first_reg, dir_reg, match_reg, nack_reg;
  logic [3:0] cnt_reg;
  logic [7:0] shift_reg;
  logic [8:0] hi_reg;
  logic rise, start, stop, ack_slot;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!arst_n);

  assign rise = scl & !scl_q_reg;
  assign start = scl & scl_q_reg & sda_q_reg & !sda;
  assign stop = scl & scl_q_reg & !sda_q_reg & sda;
  assign ack_slot = rise && (cnt_reg == 4'h8);

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      scl_q_reg <= 1'b1;
      sda_q_reg <= 1'b1;
    end else begin
      scl_q_reg <= scl;
      sda_q_reg <= sda;
    end
  end

  // Bit position in the byte, 9 is the acknowledge slot
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_reg <= 4'h0;
    end else if (start) begin
      cnt_reg <= 4'h0;
    end else if (rise) begin
      cnt_reg <= (cnt_reg == 4'h9) ? 4'h1 : cnt_reg + 4'h1;
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      shift_reg <= 8'h00;
    end else if (rise) begin
      shift_reg <= {shift_reg[6:0], sda};
    end
  end

  // Address byte decode
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      first_reg <= 1'b0;
      dir_reg <= 1'b0;
      match_reg <= 1'b0;
    end else if (start) begin
      first_reg <= 1'b1;
    end else if (stop) begin
      first_reg <= 1'b0;
      match_reg <= 1'b0;
    end else if (ack_slot && first_reg) begin
      first_reg <= 1'b0;
      dir_reg <= shift_reg[0];
      match_reg <= (shift_reg[7:1] == RTCISP_SLAVE_ADDR);
    end
  end

  // Level seen in the last acknowledge slot, high for no acknowledge
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      nack_reg <= 1'b0;
    end else if (ack_slot) begin
      nack_reg <= sda;
    end
  end

  // Cycles with the clock line high
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      hi_reg <= 9'h000;
    end else if (!scl) begin
      hi_reg <= 9'h000;
    end else if (hi_reg != 9'h1ff) begin
      hi_reg <= hi_reg + 9'h001;
    end
  end

  sequence ack_end;
    s_sda_oe ##[1:10] !s_sda_oe;
  endsequence

  a_addr_ack: assert property (
      ack_slot && first_reg |-> s_sda_oe == (shift_reg[7:1] == RTCISP_SLAVE_ADDR))
    else $error("address acknowledge wrong");
  a_write_ack: assert property (
      ack_slot && !first_reg && match_reg && !dir_reg |-> s_sda_oe)
    else $error("write byte not acknowledged");
  a_rx_released: assert property (
      rise && cnt_reg != 4'h8 && (first_reg || !dir_reg) |-> !s_sda_oe)
    else $error("port drives data while receiving");
  a_foreign_quiet: assert property (rise && !first_reg && !match_reg |-> !s_sda_oe)
    else $error("port drives data after foreign address");
  a_mack_released: assert property (
      ack_slot && !first_reg && match_reg && dir_reg |-> !s_sda_oe)
    else $error("port holds data in controller ack slot");
  a_host_released: assert property (ack_slot && (first_reg || !dir_reg) |-> !m_sda_oe)
    else $error("controller holds data in ack slot");
  // The rise after a no-acknowledge belongs to the stop, not to a data bit
  a_host_rx_quiet: assert property (
      rise && cnt_reg != 4'h8 && !(cnt_reg == 4'h9 && nack_reg) && !first_reg && match_reg
      && dir_reg |-> !m_sda_oe)
    else $error("controller drives data while port sends");
  a_ack_one_clk: assert property (
      $fell(scl) && cnt_reg == 4'h9 && match_reg && !dir_reg && !first_reg |-> ack_end)
    else $error("acknowledge not released after one clock");
  // Long clock-high stretches also cover the start lead-in, where the controller pulls data
  a_idle_high: assert property (hi_reg > 9'h12c |-> !s_sda_oe && (sda || m_sda_oe))
    else $error("data line held low while idle");
endmodule

// ==== sim/rtcisp_bench.sv ====
/*
  Bench: drives the controller end by byte commands, serves the port's
  register file and checks bytes and acknowledges. Assumes core/ files.
*/
`timescale 1ns/1ps
module rtc_i2c_slave_register_port_bench import rtcisp_pkg::*;;
  logic ref_clk = 1'b0;
  logic link_clk = 1'b0;
  logic arst_n = 1'b0;
  logic cmd_valid = 1'b0;
  logic [1:0] cmd_code = 2'h0;
  logic [7:0] cmd_byte = 8'h00;
  logic cmd_last = 1'b0;
  logic cmd_ready, rsp_valid, rsp_ack, reg_wr, busy;
  logic [7:0] rsp_byte, reg_addr, reg_wdata, reg_rdata;
  logic [7:0] mem [256];
  logic [7:0] wdat [3] = '{8'h5a, 8'hc3, 8'h00};
  int miscompares = 0;
  int n_checks = 0;
  int wr_count = 0;
  int cycles = 0;

  rtcisp_if bus_if();
  always #5 ref_clk = ~ref_clk;
  initial begin
    #2.3;
    forever #6 link_clk = ~link_clk;
  end
  assign reg_rdata = mem[reg_addr];
  always @(posedge link_clk) begin
    if (reg_wr === 1'b1) begin
      mem[reg_addr] <= reg_wdata;
      wr_count <= wr_count + 1;
    end
  end

  rtcisp_host rtcisp_host_i(.ref_clk(ref_clk), .arst_n(arst_n), .clk_en(1'b1),
    .bus(bus_if.host), .cmd_valid(cmd_valid), .cmd_code(cmd_code), .cmd_byte(cmd_byte),
    .cmd_last(cmd_last), .cmd_ready(cmd_ready), .rsp_valid(rsp_valid),
    .rsp_byte(rsp_byte), .rsp_ack(rsp_ack));
  rtcisp_dev rtcisp_dev_i(.link_clk(link_clk), .arst_n(arst_n), .clk_en(1'b1),
    .bus(bus_if.dev), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rdata(reg_rdata), .busy(busy));
  rtcisp_sva rtcisp_sva_i(.ref_clk(ref_clk), .arst_n(arst_n), .scl(bus_if.scl),
    .sda(bus_if.sda), .m_sda_oe(bus_if.m_sda_oe), .s_sda_oe(bus_if.s_sda_oe));

  task automatic results();
    if (miscompares == 0 && n_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask

  // One command; waits for the byte slot to finish unless it is a stop
  task automatic op(input logic [1:0] code, input logic [7:0] b, input logic last);
    while (cmd_ready !== 1'b1) begin
      @(posedge ref_clk);
      #1;
    end
    cmd_code = code;
    cmd_byte = b;
    cmd_last = last;
    cmd_valid = 1'b1;
    @(posedge ref_clk);
    #1;
    cmd_valid = 1'b0;
    if (code != RTCISP_CMD_STOP) begin
      while (rsp_valid !== 1'b1) begin
        @(posedge ref_clk);
        #1;
      end
    end
  endtask

  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 90000) begin
      miscompares++;
      results();
    end
  end

  initial begin
    for (int i = 0; i < 256; i++) mem[i] = 8'(i) ^ 8'ha5;
    repeat (5) @(posedge ref_clk);
    #1;
    arst_n = 1'b1;
    // Addressed write of three bytes
    op(RTCISP_CMD_START, {RTCISP_SLAVE_ADDR, 1'b0}, 1'b0);
    chk("address ack", {7'h0, rsp_ack}, 8'h01);
    chk("busy", {7'h0, busy}, 8'h01);
    op(RTCISP_CMD_WRITE, 8'h10, 1'b0);
    chk("register ack", {7'h0, rsp_ack}, 8'h01);
    for (int k = 0; k < 3; k++) begin
      op(RTCISP_CMD_WRITE, wdat[k], 1'b0);
      chk("data ack", {7'h0, rsp_ack}, 8'h01);
    end
    op(RTCISP_CMD_STOP, 8'h00, 1'b0);
    for (int k = 0; k < 3; k++) chk("stored byte", mem[8'h10 + k], wdat[k]);
    // Addressed read through a repeated start
    op(RTCISP_CMD_START, {RTCISP_SLAVE_ADDR, 1'b0}, 1'b0);
    op(RTCISP_CMD_WRITE, 8'h10, 1'b0);
    op(RTCISP_CMD_START, {RTCISP_SLAVE_ADDR, RTCISP_DIR_READ}, 1'b0);
    chk("read address ack", {7'h0, rsp_ack}, 8'h01);
    for (int k = 0; k < 3; k++) begin
      op(RTCISP_CMD_READ, 8'h00, 1'(k == 2));
      chk("read byte", rsp_byte, wdat[k]);
    end
    // Read with no register address, after a stop
    op(RTCISP_CMD_START, {RTCISP_SLAVE_ADDR, RTCISP_DIR_READ}, 1'b0);
    for (int k = 0; k < 2; k++) begin
      op(RTCISP_CMD_READ, 8'h00, 1'(k == 1));
      chk("bare read byte", rsp_byte, 8'(8'h13 + k) ^ 8'ha5);
    end
    // Foreign address is ignored
    op(RTCISP_CMD_START, {7'h33, 1'b0}, 1'b0);
    chk("foreign ack", {7'h0, rsp_ack}, 8'h00);
    chk("foreign busy", {7'h0, busy}, 8'h00);
    op(RTCISP_CMD_WRITE, 8'h20, 1'b0);
    chk("ignored data ack", {7'h0, rsp_ack}, 8'h00);
    op(RTCISP_CMD_STOP, 8'h00, 1'b0);
    // Pointer wraps past the top register
    op(RTCISP_CMD_START, {RTCISP_SLAVE_ADDR, 1'b0}, 1'b0);
    op(RTCISP_CMD_WRITE, 8'hff, 1'b0);
    op(RTCISP_CMD_WRITE, 8'h11, 1'b0);
    op(RTCISP_CMD_WRITE, 8'h22, 1'b0);
    op(RTCISP_CMD_STOP, 8'h00, 1'b0);
    while (cmd_ready !== 1'b1) begin
      @(posedge ref_clk);
      #1;
    end
    chk("top register", mem[255], 8'h11);
    chk("wrapped register", mem[0], 8'h22);
    chk("write strobes", 8'(wr_count), 8'h05);
    results();
  end
endmodule
